// *** hw/ssac_pkg.sv ***
// ssac_pkg: constants and types for the sleep, sync and alert control block
// assumes a 125 MHz core clock; all times converted to cycles here
package ssac_pkg;
  localparam int          CLK_MHZ        = 125;
  localparam int          CLK_HZ         = CLK_MHZ * 1000000;
  localparam int          WAKE_LOW_NS    = 5000;
  localparam int          WAKE_LOW_CYC   = (WAKE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int          SYNC_WAIT_MS   = 100;
  localparam int          SYNC_WAIT_CYC  = SYNC_WAIT_MS * (CLK_HZ / 1000);
  localparam int          SS_HOLD_MS     = 2000;
  localparam longint      SS_HOLD_CYC    = longint'(SS_HOLD_MS)
                                           * longint'(CLK_HZ / 1000);
  localparam int          NUM_KEYS       = 16;
  localparam logic [3:0]  LAST_KEY       = 4'hF;
  localparam logic [3:0]  FIRST_KEY      = 4'h0;
  localparam logic [7:0]  SLEEP_RESP     = 8'h5A;
  localparam logic [15:0] SCOPE_RST      = 16'h0000;
  localparam logic [1:0]  SYNC_STAGES    = 2'h2;

  typedef enum {
    SSAC_RUN,
    SSAC_SYNC_WAIT,
    SSAC_DRAIN,
    SSAC_ANNOUNCE,
    SSAC_SS_WAIT,
    SSAC_SLEEP,
    SSAC_WAKE_RESP
  } ssac_state_t;
endpackage

// *** hw/ssac_if.sv ***
// ssac_if: conditioned wake/sync line passed from the synchroniser
// assumes both ends share CLOCK
`timescale 1ns/1ps
interface ssac_if;
  logic level;
  logic fall;
  logic wake;
  modport src (output level, output fall, output wake);
  modport dst (input level, input fall, input wake);
endinterface

// *** hw/ssac_wake_sync.sv ***
// ssac_wake_sync: synchronises the wake/sync input, finds edges and lows
// assumes CLOCK at 125 MHz and a raw asynchronous input
`timescale 1ns/1ps
module ssac_wake_sync
  import ssac_pkg::*;
#(
  parameter int LOW_CYC = WAKE_LOW_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic raw,
  ssac_if.src       o
);
  initial begin
    if (LOW_CYC < 1 || LOW_CYC > 65535)
      $error("ssac_wake_sync: LOW_CYC out of range");
  end

  logic        meta_reg,  meta_next;
  logic        sync_reg,  sync_next;
  logic        prev_reg,  prev_next;
  logic [15:0] low_reg,   low_next;
  logic        wake_reg,  wake_next;

  always_comb begin
    meta_next = raw;
    sync_next = meta_reg;
    prev_next = sync_reg;
    wake_next = 1'b0;
    low_next  = low_reg;
    if (sync_reg) begin
      low_next = 16'h0000;
    end else if (low_reg != 16'(LOW_CYC)) begin
      low_next = low_reg + 16'h0001;
      wake_next = (low_reg == 16'(LOW_CYC - 1));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
      low_reg  <= 16'h0000;
      wake_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
      low_reg  <= low_next;
      wake_reg <= wake_next;
    end
  end

  assign o.level = sync_reg;
  assign o.fall  = prev_reg & ~sync_reg;
  assign o.wake  = wake_reg;
endmodule // ssac_wake_sync

// *** hw/ssac_scope_mem.sv ***
// ssac_scope_mem: volatile per-key scope-sync selection, registered read
// assumes the key index is stable while a burst is in progress
`timescale 1ns/1ps
module ssac_scope_mem
  import ssac_pkg::*;
#(
  parameter int KEYS = NUM_KEYS
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            wr_en,
  input  wire logic [KEYS-1:0] wr_mask,
  input  wire logic            wr_val,
  input  wire logic [3:0]      rd_key,
  output logic                 rd_sel
);
  initial begin
    if (KEYS != 16)
      $error("ssac_scope_mem: KEYS must be 16");
  end

  logic [KEYS-1:0] sel_reg,  sel_next;
  logic            rd_reg,   rd_next;

  always_comb begin
    sel_next = sel_reg;
    if (wr_en) begin
      sel_next = wr_val ? (sel_reg | wr_mask) : (sel_reg & ~wr_mask);
    end
    rd_next = sel_reg[rd_key];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_reg <= SCOPE_RST;
      rd_reg  <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      rd_reg  <= rd_next;
    end
  end

  assign rd_sel = rd_reg;
endmodule // ssac_scope_mem

// *** hw/ssac_ctrl.sv ***
// ssac_ctrl: sleep, noise-sync scan start, alert and scope-sync control
// assumes an acquisition engine reporting bursts and a command decoder
//
// Function
// - sleep command waits for the current burst to finish before sleeping
// - wake/sync held low at least 5 us wakes the device
// - byte that caused the wake pulse is discarded, not executed
// - wake resumes prior state with no recalibration
// - send 'Z' before sleep and another 'Z' after waking
// - slave select held low after pre-sleep reply aborts sleep, resets after 2 s
// - with sync on, wait up to 100 ms after key 15 for falling edge
// - with sync on and no edge, 100 ms gap between scans
// - sleep and sync may coexist; a sync edge wakes from sleep
// - core clock gated off during sleep until wake
// - alert held low while any key calibrates
// - alert low during each detected key's burst
// - alert high when nothing asks for low
// - alert low while any key error exists
// - alert keeps its pre-sleep level through sleep
// - scope-sync pulse spans each selected key's burst, starting a cycle late on a fresh key
// - scope-sync selection is volatile, cleared on reset
`timescale 1ns/1ps
module ssac_ctrl
  import ssac_pkg::*;
#(
  parameter int     SYNC_CYC = SYNC_WAIT_CYC,
  parameter longint HOLD_CYC = SS_HOLD_CYC,
  parameter int     LOW_CYC  = WAKE_LOW_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        WAKE_SYNC_IN,
  input  wire logic        SYNC_ENABLE,
  input  wire logic        SLEEP_CMD,
  input  wire logic        SLAVE_ONLY_SPI,
  input  wire logic        SLAVE_SEL_N,
  input  wire logic        RESP_TAKEN,
  input  wire logic        BURST_ACTIVE,
  input  wire logic        BURST_DONE,
  input  wire logic [3:0]  BURST_KEY,
  input  wire logic        KEY_DETECT,
  input  wire logic        ANY_CAL,
  input  wire logic        ANY_ERROR,
  input  wire logic        SCOPE_WR,
  input  wire logic [15:0] SCOPE_MASK,
  input  wire logic        SCOPE_VAL,
  output logic             SCAN_START,
  output logic             SCAN_HOLD,
  output logic             CLOCK_GATE_ON,
  output logic             RESP_VALID,
  output logic [7:0]       RESP_BYTE,
  output logic             CMD_DISCARD,
  output logic             FULL_RESET,
  output logic             ALERT_OUT_N,
  output logic             SCOPE_SYNC_OUT
);
  // timers are 32 bits wide, the low counter 16 bits
  initial begin
    if (SYNC_CYC < 1)
      $error("ssac_ctrl: SYNC_CYC must be at least one");
    if (HOLD_CYC < 1 || HOLD_CYC > longint'(32'hFFFF_FFFF))
      $error("ssac_ctrl: HOLD_CYC out of range");
    if (LOW_CYC < 1 || LOW_CYC > 65535)
      $error("ssac_ctrl: LOW_CYC out of range");
    if (NUM_KEYS != 16)
      $error("ssac_ctrl: key index is four bits");
  end

  ssac_if ws ();

  logic scope_sel;

  ssac_wake_sync #(.LOW_CYC(LOW_CYC)) u_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .raw   (WAKE_SYNC_IN),
    .o     (ws.src)
  );

  ssac_scope_mem #(.KEYS(NUM_KEYS)) u_scope (
    .clk     (CLOCK),
    .rst_n   (RST_N),
    .wr_en   (SCOPE_WR),
    .wr_mask (SCOPE_MASK),
    .wr_val  (SCOPE_VAL),
    .rd_key  (BURST_KEY),
    .rd_sel  (scope_sel)
  );

  ssac_state_t state_reg,  state_next;
  logic [31:0] wait_reg,   wait_next;
  logic [31:0] hold_reg,   hold_next;
  logic        start_reg,  start_next;
  logic        shold_reg,  shold_next;
  logic        gate_reg,   gate_next;
  logic        rv_reg,     rv_next;
  logic        disc_reg,   disc_next;
  logic        frst_reg,   frst_next;
  logic        alert_reg,  alert_next;
  logic        scope_reg,  scope_next;
  logic [3:0]  key_reg,    key_next;
  logic [7:0]  resp_reg,   resp_next;

  // true when the wake line signals a wake: long low or sync edge
  function automatic logic wake_event(input logic wide, input logic fall,
                                      input logic sync_on);
    return wide | (sync_on & fall);
  endfunction

  // true on the last cycle of a timer that counts up from zero
  function automatic logic timer_end(input logic [31:0] cnt,
                                     input longint      lim);
    return cnt == 32'(lim - 64'h0000_0000_0000_0001);
  endfunction

  always_comb begin
    state_next = state_reg;
    wait_next  = wait_reg;
    hold_next  = hold_reg;
    start_next = 1'b0;
    shold_next = shold_reg;
    gate_next  = gate_reg;
    rv_next    = rv_reg;
    disc_next  = 1'b0;
    frst_next  = 1'b0;
    case (state_reg)
      SSAC_RUN: begin
        if (SLEEP_CMD) begin
          state_next = SSAC_DRAIN;
        end else if (BURST_DONE && BURST_KEY == LAST_KEY && SYNC_ENABLE) begin
          state_next = SSAC_SYNC_WAIT;
          shold_next = 1'b1;
          wait_next  = 32'h0000_0000;
        end
      end
      SSAC_SYNC_WAIT: begin
        wait_next = wait_reg + 32'h0000_0001;
        if (SLEEP_CMD) begin
          state_next = SSAC_DRAIN;
        end else if (ws.fall || timer_end(wait_reg, SYNC_CYC)) begin
          state_next = SSAC_RUN;
          shold_next = 1'b0;
          start_next = 1'b1;
        end
      end
      SSAC_DRAIN: begin
        if (!BURST_ACTIVE) begin
          state_next = SSAC_ANNOUNCE;
          rv_next    = 1'b1;
        end
      end
      SSAC_ANNOUNCE: begin
        if (RESP_TAKEN) begin
          rv_next    = 1'b0;
          hold_next  = 32'h0000_0000;
          state_next = SLAVE_ONLY_SPI ? SSAC_SS_WAIT : SSAC_SLEEP;
          gate_next  = SLAVE_ONLY_SPI;
        end
      end
      SSAC_SS_WAIT: begin
        hold_next = hold_reg + 32'h0000_0001;
        if (SLAVE_SEL_N) begin
          state_next = SSAC_SLEEP;
          gate_next  = 1'b0;
        end else if (timer_end(hold_reg, HOLD_CYC)) begin
          frst_next  = 1'b1;
          state_next = SSAC_RUN;
          gate_next  = 1'b1;
        end
      end
      SSAC_SLEEP: begin
        gate_next = 1'b0;
        if (wake_event(ws.wake, ws.fall, SYNC_ENABLE)) begin
          gate_next  = 1'b1;
          disc_next  = 1'b1;
          rv_next    = 1'b1;
          state_next = SSAC_WAKE_RESP;
        end
      end
      SSAC_WAKE_RESP: begin
        if (RESP_TAKEN) begin
          rv_next    = 1'b0;
          state_next = shold_reg ? SSAC_SYNC_WAIT : SSAC_RUN;
        end
      end
      default: begin
        state_next = SSAC_RUN;
        gate_next  = 1'b1;
      end
    endcase
  end

  // alert and scope-sync follow the bursts; alert frozen and scope-sync held low while asleep
  always_comb begin
    alert_next = alert_reg;
    scope_next = 1'b0;
    key_next   = BURST_KEY;
    resp_next  = SLEEP_RESP;
    if (state_reg != SSAC_SLEEP) begin
      alert_next = ~(ANY_CAL
                   | (BURST_ACTIVE & KEY_DETECT)
                   | ANY_ERROR);
      // selection read lags the key a cycle; a fresh key must wait
      scope_next = BURST_ACTIVE & scope_sel
                 & (key_reg == BURST_KEY);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      alert_reg <= 1'b1;
      scope_reg <= 1'b0;
      key_reg   <= FIRST_KEY;
      resp_reg  <= SLEEP_RESP;
    end else begin
      alert_reg <= alert_next;
      scope_reg <= scope_next;
      key_reg   <= key_next;
      resp_reg  <= resp_next;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_reg <= SSAC_RUN;
      wait_reg  <= 32'h0000_0000;
      hold_reg  <= 32'h0000_0000;
      start_reg <= 1'b0;
      shold_reg <= 1'b0;
      gate_reg  <= 1'b1;
      rv_reg    <= 1'b0;
      disc_reg  <= 1'b0;
      frst_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
      hold_reg  <= hold_next;
      start_reg <= start_next;
      shold_reg <= shold_next;
      gate_reg  <= gate_next;
      rv_reg    <= rv_next;
      disc_reg  <= disc_next;
      frst_reg  <= frst_next;
    end
  end

  assign SCAN_START     = start_reg;
  assign SCAN_HOLD      = shold_reg;
  assign CLOCK_GATE_ON  = gate_reg;
  assign RESP_VALID     = rv_reg;
  assign RESP_BYTE      = resp_reg;
  assign CMD_DISCARD    = disc_reg;
  assign FULL_RESET     = frst_reg;
  assign ALERT_OUT_N    = alert_reg;
  assign SCOPE_SYNC_OUT = scope_reg;
endmodule // ssac_ctrl

// *** testbench/ssac_checker.sv ***
// ssac_checker: port timing of the sleep, sync and alert control
// assumes the bind below and a shortened sync wait
`timescale 1ns/1ps
module ssac_checker #(
  parameter int SYNC_CYC = 50
) (
  input wire logic       CLOCK,
  input wire logic       RST_N,
  input wire logic       WAKE_SYNC_IN,
  input wire logic       SYNC_ENABLE,
  input wire logic       BURST_ACTIVE,
  input wire logic       BURST_DONE,
  input wire logic [3:0] BURST_KEY,
  input wire logic       KEY_DETECT,
  input wire logic       ANY_CAL,
  input wire logic       ANY_ERROR,
  input wire logic       SCAN_START,
  input wire logic       SCAN_HOLD,
  input wire logic       CLOCK_GATE_ON,
  input wire logic       CMD_DISCARD,
  input wire logic       ALERT_OUT_N,
  input wire logic       SCOPE_SYNC_OUT
);
  localparam int HB = SYNC_CYC + 3;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // two awake samples, so a freeze held into the first cycle after wake never counts
  sequence s_up2; CLOCK_GATE_ON ##1 CLOCK_GATE_ON; endsequence
  sequence s_dn2; !CLOCK_GATE_ON ##1 !CLOCK_GATE_ON; endsequence
  a_alert_cal: assert property (ANY_CAL ##0 s_up2 |-> !ALERT_OUT_N)
    else $error("alert high while calibrating");
  a_alert_err: assert property (ANY_ERROR ##0 s_up2 |-> !ALERT_OUT_N)
    else $error("alert high with key error");
  a_alert_key: assert property (BURST_ACTIVE && KEY_DETECT ##0 s_up2
    |-> !ALERT_OUT_N)
    else $error("alert high in detected burst");
  a_alert_frozen: assert property (s_dn2 |-> $stable(ALERT_OUT_N))
    else $error("alert moved in sleep");
  a_scope_burst: assert property (SCOPE_SYNC_OUT && CLOCK_GATE_ON
    |-> $past(BURST_ACTIVE))
    else $error("scope pulse outside burst");
  a_hold_cause: assert property ($rose(SCAN_HOLD) |->
    $past(BURST_DONE && BURST_KEY == 4'hF && SYNC_ENABLE))
    else $error("hold without last key");
  a_hold_bound: assert property ($rose(SCAN_HOLD) |-> ##[1:HB] SCAN_START)
    else $error("sync wait too long");
  a_sync_fall: assert property (SCAN_HOLD && $fell(WAKE_SYNC_IN)
    |-> ##[1:5] SCAN_START)
    else $error("no scan start on sync edge");
  a_wake_low: assert property (!CLOCK_GATE_ON ##0 !WAKE_SYNC_IN[*8]
    |-> ##[0:2] CLOCK_GATE_ON)
    else $error("no wake on long low");
  a_wake_discard: assert property ($rose(CLOCK_GATE_ON)
    |-> ##[0:1] CMD_DISCARD)
    else $error("wake byte not discarded");
  a_sleep_drain: assert property ($fell(CLOCK_GATE_ON)
    |-> !$past(BURST_ACTIVE))
    else $error("slept during burst");
  a_alert_idle: assert property (!ANY_CAL && !ANY_ERROR
    && !BURST_ACTIVE ##0 s_up2 |-> ALERT_OUT_N)
    else $error("alert low with no cause");
  a_scope_key: assert property (SCOPE_SYNC_OUT && CLOCK_GATE_ON
    |-> $past(BURST_KEY) == $past(BURST_KEY, 2))
    else $error("scope pulse on a fresh key");
endmodule // ssac_checker
bind ssac_ctrl ssac_checker #(.SYNC_CYC(SYNC_CYC)) i_ssac_checker (.*);

// *** testbench/ssac_host_model.sv ***
// ssac_host_model: host driving the wake line and taking replies
// assumes the bench calls low() and reads zs
`timescale 1ns/1ps
module ssac_host_model (
  input  wire logic       clk,
  input  wire logic       resp_valid,
  input  wire logic [7:0] resp_byte,
  input  wire logic       alert_n,
  output logic            wake_sync_in,
  output logic            resp_taken
);
  int n = 0;
  int zs = 0;
  int polls = 0;
  logic alert_was = 1'b1;
  // a falling alert is the interrupt; each one starts a status poll
  always @(negedge clk) begin
    alert_was <= alert_n;
    if (alert_was === 1'b1 && alert_n === 1'b0) polls <= polls + 1;
  end
  initial wake_sync_in = 1'b1;
  initial resp_taken = 1'b0;
  // slow take, three idle cycles, keeps the reply pending a while
  always @(negedge clk) begin
    resp_taken <= 1'b0;
    n <= resp_valid ? n + 1 : 0;
    if (resp_valid && n == 3) begin
      resp_taken <= 1'b1;
      zs <= zs + (resp_byte === 8'h5A);
    end
  end
  task automatic low(input int c);
    @(negedge clk);
    wake_sync_in = 1'b0;
    repeat (c) @(negedge clk);
    wake_sync_in = 1'b1;
  endtask
endmodule // ssac_host_model

// *** testbench/test_sleep_sync_alert_control.sv ***
// test_sleep_sync_alert_control: self-checking bench for ssac_ctrl
// assumes the host model and a shortened sync, hold and low count
`timescale 1ns/1ps
module test_sleep_sync_alert_control;
  logic CLOCK = 0, RST_N = 0, SYNC_ENABLE = 0, SLEEP_CMD = 0, g;
  logic SLAVE_ONLY_SPI = 0, SLAVE_SEL_N = 1, BURST_ACTIVE = 0;
  logic BURST_DONE = 0, KEY_DETECT = 0, ANY_CAL = 0, ANY_ERROR = 0;
  logic SCOPE_WR = 0, SCOPE_VAL = 0;
  logic [3:0] BURST_KEY = 4'h0;
  logic [15:0] SCOPE_MASK = 16'h0000;
  logic WAKE_SYNC_IN, RESP_TAKEN, SCAN_START, SCAN_HOLD, CLOCK_GATE_ON;
  logic RESP_VALID, CMD_DISCARD, FULL_RESET, ALERT_OUT_N, SCOPE_SYNC_OUT;
  logic [7:0] RESP_BYTE;
  int fails = 0, checked = 0, cyc = 0, disc = 0, n;
  always #4 CLOCK = ~CLOCK;
  ssac_ctrl #(.SYNC_CYC(50), .HOLD_CYC(40), .LOW_CYC(4)) i_ssac_ctrl (.*);
  ssac_host_model i_ssac_host_model (.clk(CLOCK), .resp_valid(RESP_VALID),
    .resp_byte(RESP_BYTE), .alert_n(ALERT_OUT_N),
    .wake_sync_in(WAKE_SYNC_IN),
    .resp_taken(RESP_TAKEN));
  always @(posedge CLOCK) begin
    cyc++;
    if (CMD_DISCARD === 1'b1) disc++;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cy(input int c);
    repeat (c) @(negedge CLOCK);
  endtask
  task automatic wait_start();
    n = 0;
    while (SCAN_START !== 1'b1 && n < 200) begin
      cy(1);
      n++;
    end
  endtask
  // exp is {alert, scope} sampled mid-burst
  task automatic burst(input logic [3:0] k, input logic d, input logic [1:0] e);
    cy(1);
    BURST_ACTIVE = 1'b1;
    BURST_KEY = k;
    KEY_DETECT = d;
    cy(2);
    chk({ALERT_OUT_N, SCOPE_SYNC_OUT}, e);
    BURST_DONE = 1'b1;
    cy(1);
    {BURST_ACTIVE, BURST_DONE, KEY_DETECT} = 3'h0;
  endtask
  task automatic scope(input logic [15:0] m, input logic v);
    SCOPE_MASK = m;
    SCOPE_VAL = v;
    SCOPE_WR = 1'b1;
    cy(1);
    SCOPE_WR = 1'b0;
  endtask
  task automatic t_alert();
    ANY_CAL = 1'b1;
    cy(2);
    chk(ALERT_OUT_N, 0);
    ANY_CAL = 1'b0;
    ANY_ERROR = 1'b1;
    cy(2);
    chk(ALERT_OUT_N, 0);
    ANY_ERROR = 1'b0;
    cy(2);
    chk(ALERT_OUT_N, 1);
    burst(4'h3, 1, 2'h0);
    burst(4'h4, 0, 2'h2);
    chk(i_ssac_host_model.polls, 2);
    $display("t_alert end");
  endtask
  task automatic t_scope();
    burst(4'h5, 0, 2'h2);
    scope(16'h00F0, 1);
    burst(4'h5, 0, 2'h3);
    burst(4'h6, 1, 2'h1);
    burst(4'h9, 0, 2'h2);
    scope(16'h0020, 0);
    burst(4'h5, 0, 2'h2);
    burst(4'h7, 0, 2'h3);
    $display("t_scope end");
  endtask
  task automatic t_sync();
    SYNC_ENABLE = 1'b1;
    burst(4'hF, 0, 2'h2);
    cy(1);
    chk(SCAN_HOLD, 1);
    fork
      i_ssac_host_model.low(2);
      wait_start();
    join
    chk(n <= 6, 1);
    burst(4'hF, 0, 2'h2);
    wait_start();
    chk(n inside {[45:56]}, 1);
    SYNC_ENABLE = 1'b0;
    $display("t_sync end");
  endtask
  task automatic t_sleep(input logic s);
    int z0, d0;
    z0 = i_ssac_host_model.zs;
    d0 = disc;
    ANY_ERROR = 1'b1;
    BURST_ACTIVE = 1'b1;
    SLEEP_CMD = 1'b1;
    cy(1);
    SLEEP_CMD = 1'b0;
    cy(4);
    chk({CLOCK_GATE_ON, RESP_VALID}, 2'h2);
    BURST_DONE = 1'b1;
    BURST_ACTIVE = 1'b0;
    cy(1);
    BURST_DONE = 1'b0;
    n = 0;
    while (CLOCK_GATE_ON !== 1'b0 && n < 50) begin
      cy(1);
      n++;
    end
    // error cleared only once asleep, so the low alert must hold
    ANY_ERROR = 1'b0;
    chk(i_ssac_host_model.zs - z0, 1);
    SYNC_ENABLE = s;
    i_ssac_host_model.low(2);
    cy(8);
    chk({CLOCK_GATE_ON, ALERT_OUT_N}, {s, s});
    if (!s) i_ssac_host_model.low(9);
    cy(8);
    chk(CLOCK_GATE_ON, 1);
    chk(disc - d0, 1);
    chk(i_ssac_host_model.zs - z0, 2);
    SYNC_ENABLE = 1'b0;
    $display("t_sleep end");
  endtask
  task automatic t_ss();
    SLAVE_ONLY_SPI = 1'b1;
    SLAVE_SEL_N = 1'b0;
    SLEEP_CMD = 1'b1;
    cy(1);
    SLEEP_CMD = 1'b0;
    g = 1'b1;
    n = 0;
    while (FULL_RESET !== 1'b1 && n < 200) begin
      cy(1);
      g = g & CLOCK_GATE_ON;
      n++;
    end
    chk({n inside {[40:60]}, g}, 2'h3);
    RST_N = 1'b0;
    cy(4);
    RST_N = 1'b1;
    SLAVE_ONLY_SPI = 1'b0;
    SLAVE_SEL_N = 1'b1;
    cy(2);
    burst(4'h7, 0, 2'h2);
    SLAVE_ONLY_SPI = 1'b1;
    SLAVE_SEL_N = 1'b0;
    SLEEP_CMD = 1'b1;
    cy(1);
    SLEEP_CMD = 1'b0;
    n = 0;
    while (i_ssac_host_model.resp_taken !== 1'b1 && n < 50) begin
      cy(1);
      n++;
    end
    SLAVE_SEL_N = 1'b1;
    cy(4);
    chk({CLOCK_GATE_ON, FULL_RESET}, 2'h0);
    i_ssac_host_model.low(9);
    cy(8);
    chk(CLOCK_GATE_ON, 1);
    SLAVE_ONLY_SPI = 1'b0;
    $display("t_ss end");
  endtask
  initial begin
    cy(8);
    RST_N = 1'b1;
    cy(2);
    t_alert();
    t_scope();
    t_sync();
    t_sleep(0);
    t_sleep(1);
    t_ss();
    tally_and_finish();
  end
endmodule // test_sleep_sync_alert_control
